//--- logic/secure_otp_defs.vh
// constants for the secured area and security status command logic
// assumes inclusion by bare name from the logic/ files
`ifndef SECURE_OTP_DEFS_VH
`define SECURE_OTP_DEFS_VH
// command opcodes (values arbitrary within this block)
`define OP_ENTER_SECURE   8'hB1
`define OP_EXIT_SECURE    8'hC1
`define OP_READ_SECSTAT   8'h2B
`define OP_WRITE_SECSTAT  8'h2F
`define OP_WRITE_ENABLE   8'h06
// security status bit positions
`define SS_PROT_MODE      7
`define SS_ERASE_FAIL     6
`define SS_PROG_FAIL      5
`define SS_RESERVED       4
`define SS_ERASE_SUSP     3
`define SS_PROG_SUSP      2
`define SS_LOCKDOWN       1
`define SS_FACTORY_LOCK   0
// frame counting
`define BITS_PER_BYTE     4'h8
`define NIBS_PER_BYTE     4'h2
`define CNT_ZERO          4'h0
`define CNT_ONE           4'h1
`endif

//--- logic/sync2.v
// two flip-flop synchroniser for a group of level inputs
// assumes inputs asynchronous to clk_in
`timescale 1ns/1ps
module sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_in,
    input  wire             rst_b_in,
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] q_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] q_r;
    // -----------------------------------------------------------------
    // two stage capture
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r <= {WIDTH{1'b0}};
            q_r    <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_in;
            q_r    <= meta_r;
        end
    end
    assign q_out = q_r;
endmodule // sync2

//--- logic/edge_find.v
// finds rising and falling edges of a synchronised serial clock
// assumes input already synchronised to clk_in
`timescale 1ns/1ps
module edge_find (
    input  wire clk_in,
    input  wire rst_b_in,
    input  wire level_in,
    output wire rise_out,
    output wire fall_out
);
    reg last_r;
    // -----------------------------------------------------------------
    // delay by one clock
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_r <= 1'b0;
        end else begin
            last_r <= level_in;
        end
    end
    assign rise_out = level_in & ~last_r;
    assign fall_out = ~level_in & last_r;
endmodule // edge_find

//--- logic/secure_otp_ctrl.v
// command logic for the secured area, lock-down and security status
// assumes host drives chip select, serial clock and four io lines;
// array engines report fail, suspend and busy as clk_in levels/pulses
//
// Contract
// RULE1 - enter command selects secured region only
// RULE2 - reads and programs steer to secured region
// RULE3 - exit command restores main array access
// RULE4 - host sends opcode only inside frame
// RULE5 - opcode as 8 single or 2 quad clocks
// RULE6 - locked region accepts reads, refuses programs
// RULE7 - status read served even while busy
// RULE8 - status byte repeats until chip select rises
// RULE9 - host sets write enable before status write
// RULE10 - status write sets lock-down, then frozen
// RULE11 - status write needs byte-aligned chip select rise
// RULE12 - erase fail set on fail, cleared on success
// RULE13 - program fail set on fail, cleared on success
// RULE14 - erase suspended flag follows suspend/resume
// RULE15 - program suspended flag follows suspend/resume
// RULE16 - bit0 reports factory lock
// RULE17 - bit7 protection mode, bit4 reserved
// RULE18 - protection mode bit never returns zero
// RULE19 - writes to read-only bits ignored
`timescale 1ns/1ps
`include "secure_otp_defs.vh"
module secure_otp_ctrl #(
    parameter FACTORY_LOCK = 1'b0
) (
    input  wire       clk_in,
    input  wire       rst_b_in,
    input  wire       cs_b_in,
    input  wire       sclk_in,
    input  wire [3:0] sio_in,
    output wire [3:0] sio_out,
    output wire [3:0] sio_oe_out,
    input  wire       quad_command_mode_in,
    input  wire       busy_in,
    input  wire       erase_done_in,
    input  wire       erase_ok_in,
    input  wire       prog_done_in,
    input  wire       prog_ok_in,
    input  wire       erase_suspend_in,
    input  wire       erase_resume_in,
    input  wire       prog_suspend_in,
    input  wire       prog_resume_in,
    input  wire       prot_mode_set_in,
    output wire       secure_mode_out,
    output wire       array_prog_allow_out,
    output wire       write_enable_latch_out,
    output wire [7:0] security_status_out
);
    // -----------------------------------------------------------------
    // pin synchronisation and edge finding
    // -----------------------------------------------------------------
    wire [5:0] pins_s;
    wire       cs_b_s;
    wire       sclk_s;
    wire [3:0] sio_s;
    wire       sclk_rise;
    wire       sclk_fall;
    sync2 #(.WIDTH(6)) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .d_in     ({~cs_b_in, sclk_in, sio_in}), // select held active high
        .q_out    (pins_s)
    );
    // stored inverted so the synchroniser's reset value reads as deselected
    assign cs_b_s = ~pins_s[5];
    assign sclk_s = pins_s[4];
    assign sio_s  = pins_s[3:0];
    edge_find u_edge (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .level_in (sclk_s),
        .rise_out (sclk_rise),
        .fall_out (sclk_fall)
    );

    // -----------------------------------------------------------------
    // frame state
    // -----------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_OPC  = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [7:0] shift_r;
    reg  [3:0] cnt_r;
    reg  [7:0] opcode_r;
    reg        cs_last_r;
    reg        reading_r;
    reg  [7:0] out_r;
    reg  [3:0] ocnt_r;
    reg        sio_drv_r;
    reg        secure_r;
    reg        lockdown_r;
    reg        wel_r;
    reg        efail_r;
    reg        pfail_r;
    reg        esusp_r;
    reg        psusp_r;
    reg        prot_mode_r;
    reg        factory_r;
    reg        strap_done_r;

    wire       frame_start = cs_last_r & ~cs_b_s;
    wire       frame_end   = ~cs_last_r & cs_b_s;
    wire       quad        = quad_command_mode_in;
    wire [3:0] opc_len     = quad ? `NIBS_PER_BYTE : `BITS_PER_BYTE;
    // assembled byte on the final opcode clock
    wire [7:0] byte_nxt    = quad ? {shift_r[3:0], sio_s}
                                  : {shift_r[6:0], sio_s[0]}; // see RULE5
    wire       last_clk    = (cnt_r == opc_len - `CNT_ONE);
    wire [7:0] status_byte;

    // -----------------------------------------------------------------
    // state sequencing
    // -----------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (frame_start) begin
                    state_nxt = ST_OPC;
                end
            end
            ST_OPC: begin
                if (cs_b_s) begin
                    state_nxt = ST_IDLE;
                end else if (sclk_rise && last_clk) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (cs_b_s) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // -----------------------------------------------------------------
    // opcode capture and extra clock counting
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r   <= ST_IDLE;
            shift_r   <= 8'h00;
            cnt_r     <= `CNT_ZERO;
            opcode_r  <= 8'h00;
            cs_last_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            cs_last_r <= cs_b_s;
            if (frame_start) begin
                cnt_r   <= `CNT_ZERO;
                shift_r <= 8'h00;
            end else if (state_r == ST_OPC && sclk_rise) begin
                shift_r <= byte_nxt;
                cnt_r   <= last_clk ? `CNT_ZERO : cnt_r + `CNT_ONE;
                if (last_clk) begin
                    opcode_r <= byte_nxt;
                end
            end else if (state_r == ST_DONE && sclk_rise) begin
                // clocks after the opcode must fill whole bytes to align
                cnt_r <= last_clk ? `CNT_ZERO : cnt_r + `CNT_ONE; // see RULE11
            end
        end
    end

    // aligned frame end after the opcode plus any whole bytes of extra clocks
    wire clean_end = frame_end && state_r == ST_DONE
                     && cnt_r == `CNT_ZERO;                  // see RULE4
    wire do_enter  = clean_end && opcode_r == `OP_ENTER_SECURE;
    wire do_exit   = clean_end && opcode_r == `OP_EXIT_SECURE;
    wire do_wrsec  = clean_end && opcode_r == `OP_WRITE_SECSTAT; // see RULE11
    wire do_write_enable_cmd   = clean_end && opcode_r == `OP_WRITE_ENABLE;

    // -----------------------------------------------------------------
    // secured mode and write enable latch
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            secure_r <= 1'b0;
            wel_r    <= 1'b0;
        end else begin
            if (do_enter) begin
                secure_r <= 1'b1;                            // see RULE1
            end else if (do_exit) begin
                secure_r <= 1'b0;                            // see RULE3
            end
            if (do_write_enable_cmd) begin
                wel_r <= 1'b1;
            end else if (do_wrsec) begin
                wel_r <= 1'b0;                               // see RULE9
            end
        end
    end

    // -----------------------------------------------------------------
    // non-volatile bits: factory strap caught after reset release
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            factory_r    <= 1'b0;
            strap_done_r <= 1'b0;
            lockdown_r   <= 1'b0;
            prot_mode_r  <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
            if (!strap_done_r) begin
                factory_r <= FACTORY_LOCK;                   // see RULE16
            end
            // only setting is possible, clear attempts do nothing
            if (do_wrsec && wel_r && !lockdown_r) begin
                lockdown_r <= 1'b1;                          // see RULE10
            end
            if (prot_mode_set_in) begin
                prot_mode_r <= 1'b1;                         // see RULE18
            end
        end
    end

    // -----------------------------------------------------------------
    // volatile status flags, set wins over clear
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            efail_r <= 1'b0;
            pfail_r <= 1'b0;
            esusp_r <= 1'b0;
            psusp_r <= 1'b0;
        end else begin
            if (erase_done_in) begin
                efail_r <= ~erase_ok_in;                     // see RULE12
            end
            if (prog_done_in) begin
                pfail_r <= ~prog_ok_in;                      // see RULE13
            end
            if (erase_suspend_in) begin
                esusp_r <= 1'b1;                             // see RULE14
            end else if (erase_resume_in) begin
                esusp_r <= 1'b0;
            end
            if (prog_suspend_in) begin
                psusp_r <= 1'b1;                             // see RULE15
            end else if (prog_resume_in) begin
                psusp_r <= 1'b0;
            end
        end
    end

    // status byte, reserved bit reads zero; writes touch only lock-down
    assign status_byte[`SS_PROT_MODE]    = prot_mode_r;      // see RULE17
    assign status_byte[`SS_ERASE_FAIL]   = efail_r;
    assign status_byte[`SS_PROG_FAIL]    = pfail_r;
    assign status_byte[`SS_RESERVED]     = 1'b0;             // see RULE19
    assign status_byte[`SS_ERASE_SUSP]   = esusp_r;
    assign status_byte[`SS_PROG_SUSP]    = psusp_r;
    assign status_byte[`SS_LOCKDOWN]     = lockdown_r;
    assign status_byte[`SS_FACTORY_LOCK] = factory_r;

    // -----------------------------------------------------------------
    // status read-out, no busy gate so it works mid operation
    // -----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reading_r <= 1'b0;
            out_r     <= 8'h00;
            ocnt_r    <= `CNT_ZERO;
            sio_drv_r <= 1'b0;
        end else if (cs_b_s) begin
            reading_r <= 1'b0;                               // see RULE8
            sio_drv_r <= 1'b0;
        end else if (state_r == ST_OPC && sclk_rise && last_clk
                     && byte_nxt == `OP_READ_SECSTAT) begin
            reading_r <= 1'b1;                               // see RULE7
            out_r     <= status_byte;
            ocnt_r    <= `CNT_ZERO;
        end else if (reading_r && sclk_fall) begin
            sio_drv_r <= 1'b1;
            if (ocnt_r == `CNT_ZERO) begin
                out_r <= status_byte;                        // see RULE8
            end else begin
                out_r <= quad ? {out_r[3:0], 4'h0}
                              : {out_r[6:0], 1'b0};
            end
            ocnt_r <= (ocnt_r == opc_len - `CNT_ONE) ? `CNT_ZERO
                                                      : ocnt_r + `CNT_ONE;
        end
    end

    // single mode drives line 1, quad mode drives all four
    assign sio_out    = quad ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
    assign sio_oe_out = !sio_drv_r ? 4'h0 : (quad ? 4'hF : 4'h2);

    // array steering outputs for the program and read engines
    assign secure_mode_out        = secure_r;                // see RULE2
    assign array_prog_allow_out   = ~(secure_r & lockdown_r); // see RULE6
    assign write_enable_latch_out = wel_r;
    assign security_status_out    = status_byte;
    // busy is not decoded and reaches no status bit; reads never wait
    wire unused_busy = busy_in;
endmodule // secure_otp_ctrl

//--- sim/secure_otp_ctrl_chk.sv
// assertions on the security status command block ports
// assumes one clk_in domain with async active-low reset
`timescale 1ns/1ps
module secure_otp_ctrl_chk #(
    parameter FACTORY_LOCK = 1'b0
) (
    input wire       clk_in,
    input wire       rst_b_in,
    input wire       cs_b_in,
    input wire       erase_done_in,
    input wire       erase_ok_in,
    input wire       erase_suspend_in,
    input wire       prog_suspend_in,
    input wire       prog_resume_in,
    input wire       prot_mode_set_in,
    input wire       secure_mode_out,
    input wire       array_prog_allow_out,
    input wire [7:0] security_status_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_b_in);
// ----------------------------------------
// mode, lock-down and flag relations
// ----------------------------------------
property p_mode_edge; $changed(secure_mode_out) |-> cs_b_in; endproperty
a_mode_edge: assert property (p_mode_edge)
    else $error("secure mode moved inside a frame");
property p_allow;
    array_prog_allow_out == !(secure_mode_out && security_status_out[1]);
endproperty
a_allow: assert property (p_allow)
    else $error("program allow wrong for lock state");
property p_lock_hold;
    $past(security_status_out[1]) |-> security_status_out[1];
endproperty
a_lock_hold: assert property (p_lock_hold)
    else $error("lock-down bit cleared");
property p_prot_hold;
    $past(security_status_out[7]) |-> security_status_out[7];
endproperty
a_prot_hold: assert property (p_prot_hold)
    else $error("protection mode bit returned to zero");
property p_prot_set; prot_mode_set_in |-> ##[1:3] security_status_out[7];
endproperty
a_prot_set: assert property (p_prot_set)
    else $error("protection mode bit not set");
property p_factory;
    $past(rst_b_in) |-> security_status_out[0] == FACTORY_LOCK;
endproperty
a_factory: assert property (p_factory)
    else $error("factory lock bit wrong");
property p_efail;
    erase_done_in && !erase_ok_in |-> ##[1:3] security_status_out[6];
endproperty
a_efail: assert property (p_efail)
    else $error("erase fail flag not set");
property p_esusp; erase_suspend_in |-> ##[1:3] security_status_out[3];
endproperty
a_esusp: assert property (p_esusp)
    else $error("erase suspended flag not set");
property p_presume;
    prog_resume_in && !prog_suspend_in |-> ##[1:3] !security_status_out[2];
endproperty
a_presume: assert property (p_presume)
    else $error("program suspended flag not cleared");
endmodule // secure_otp_ctrl_chk

bind secure_otp_ctrl secure_otp_ctrl_chk #(.FACTORY_LOCK(FACTORY_LOCK)) chk_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in),
    .erase_done_in(erase_done_in), .erase_ok_in(erase_ok_in),
    .erase_suspend_in(erase_suspend_in), .prog_suspend_in(prog_suspend_in),
    .prog_resume_in(prog_resume_in), .prot_mode_set_in(prot_mode_set_in),
    .secure_mode_out(secure_mode_out),
    .array_prog_allow_out(array_prog_allow_out),
    .security_status_out(security_status_out));

//--- sim/secure_otp_host.sv
// host controller model driving framed opcode cycles
// assumes the bench resolves the io lines from the device enables
`timescale 1ns/1ps
`include "secure_otp_defs.vh"
module secure_otp_host (
    output reg       cs_b_out,
    output reg       sclk_out,
    output reg [3:0] sio_out,
    input  wire [3:0] sio_in
);
reg [3:0] got;
// serial clock idles low between frames
initial begin
    cs_b_out = 1'b1;
    sclk_out = 1'b0;
    sio_out = 4'h0;
    got = 4'h0;
end
// one 200 ns serial clock, lines sampled on the rise
task tick(input [3:0] d);
begin
    sio_out = d;
    #100 sclk_out = 1'b1;
    got = sio_in;
    #100 sclk_out = 1'b0;
end endtask
// opcode only, upper lines carry junk in single mode
task cmd_open(input [7:0] op, input q);
    integer i;
begin
    cs_b_out = 1'b0;
    #100;
    if (q) begin
        tick(op[7:4]);
        tick(op[3:0]);
    end else for (i = 7; i >= 0; i = i - 1) tick({3'h5, op[i]});
end endtask
// lines released after the frame keep changing
task cmd_close;
begin
    #100 cs_b_out = 1'b1;
    sio_out = ~sio_out;
    #300;
end endtask
// extra clocks push the rise off the byte boundary
task frame(input [7:0] op, input q, input integer extra);
    integer i;
begin
    cmd_open(op, q);
    for (i = 0; i < extra; i = i + 1) tick(4'hA);
    cmd_close;
end endtask
// status read, two whole bytes collected
task rd(input q, output [15:0] v);
    integer i;
begin
    v = 16'h0000;
    cmd_open(`OP_READ_SECSTAT, q);
    for (i = 0; i < (q ? 4 : 16); i = i + 1) begin
        tick(~sio_out);
        v = q ? {v[11:0], got} : {v[14:0], got[1]};
    end
    cmd_close;
end endtask
endmodule // secure_otp_host

//--- sim/secure_otp_and_security_status_test.sv
// self-checking bench for the secured area command block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`include "secure_otp_defs.vh"
module secure_otp_and_security_status_test;
reg        clk_in = 1'b0;
reg        rst_b_in = 1'b0;
reg        quad_in = 1'b0;
reg        busy_in = 1'b0;
reg  [8:0] ev = 9'h000;
wire       cs_b, sclk, smode, allow, write_enable_latch;
wire [3:0] h_sio, d_sio, d_oe;
wire [7:0] stat;
integer    failures = 0, n_checks = 0, i;
reg  [7:0] exp;
reg [15:0] rv;
reg  [8:0] pv [0:9] = '{9'h001, 9'h003, 9'h004, 9'h00C, 9'h010,
                        9'h020, 9'h040, 9'h080, 9'h100, 9'h041};
reg  [7:0] pe [0:9] = '{8'h43, 8'h03, 8'h23, 8'h03, 8'h0B,
                        8'h03, 8'h07, 8'h03, 8'h83, 8'hC7};
// io wire level from both parties
wire [3:0] line = (d_oe & d_sio) | (~d_oe & h_sio);
always #12.5 clk_in = ~clk_in;
secure_otp_host host (.cs_b_out(cs_b), .sclk_out(sclk), .sio_out(h_sio),
    .sio_in(line));
secure_otp_ctrl #(.FACTORY_LOCK(1'b1)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk),
    .sio_in(line), .sio_out(d_sio), .sio_oe_out(d_oe),
    .quad_command_mode_in(quad_in), .busy_in(busy_in),
    .erase_done_in(ev[0]), .erase_ok_in(ev[1]), .prog_done_in(ev[2]),
    .prog_ok_in(ev[3]), .erase_suspend_in(ev[4]), .erase_resume_in(ev[5]),
    .prog_suspend_in(ev[6]), .prog_resume_in(ev[7]),
    .prot_mode_set_in(ev[8]), .secure_mode_out(smode),
    .array_prog_allow_out(allow), .write_enable_latch_out(write_enable_latch),
    .security_status_out(stat));
task chk(input [8*8:1] nm, input [7:0] seen, input [7:0] ex);
begin
    n_checks = n_checks + 1;
    if (seen !== ex) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, ex, seen);
    end
end endtask
// one-cycle engine event pulse, then settle
task pulse(input [8:0] p);
begin
    @(posedge clk_in) #2 ev = p;
    @(posedge clk_in) #2 ev = 9'h000;
    repeat (4) @(posedge clk_in);
    #2;
end endtask
task report_and_stop;
begin
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
end endtask
// hang guard
initial begin
    #400000 failures = failures + 1;
    report_and_stop;
end
// ----------------------------------------
// test sequence
// ----------------------------------------
initial begin
    repeat (5) @(posedge clk_in);
    #2 rst_b_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2;
    exp = 8'h01;
    chk("reset", stat, exp);
    chk("allow", {7'h00, allow}, 8'h01);
    host.frame(`OP_ENTER_SECURE, 1'b0, 0);
    chk("enter", {7'h00, smode}, 8'h01);
    host.rd(1'b0, rv);
    chk("rd_a", rv[15:8], exp);
    chk("rd_b", rv[7:0], exp);
    @(posedge clk_in) #2 quad_in = 1'b1;
    host.frame(`OP_EXIT_SECURE, 1'b1, 0);
    chk("exit", {7'h00, smode}, 8'h00);
    host.frame(`OP_ENTER_SECURE, 1'b1, 1);
    chk("extra", {7'h00, smode}, 8'h00);
    $display("test modes done");
    host.frame(`OP_WRITE_SECSTAT, 1'b1, 0);
    chk("nowel", stat, exp);
    host.frame(`OP_WRITE_ENABLE, 1'b1, 0);
    chk("wel", {7'h00, write_enable_latch}, 8'h01);
    host.frame(`OP_WRITE_SECSTAT, 1'b1, 1);
    chk("misalign", stat, exp);
    host.frame(`OP_WRITE_ENABLE, 1'b1, 0);
    host.frame(`OP_WRITE_SECSTAT, 1'b1, 0);
    exp = 8'h03;
    chk("lock", stat, exp);
    host.frame(`OP_ENTER_SECURE, 1'b1, 0);
    chk("noprog", {7'h00, allow}, 8'h00);
    host.frame(`OP_EXIT_SECURE, 1'b1, 0);
    $display("test lock done");
    @(posedge clk_in) #2 busy_in = 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
        pulse(pv[i]);
        chk("flags", stat, pe[i]);
    end
    pulse(9'h030);
    chk("susp_win", stat, 8'hCF);
    pulse(9'h020);
    chk("resume", stat, 8'hC7);
    host.rd(1'b1, rv);
    chk("busy_a", rv[15:8], 8'hC7);
    chk("busy_b", rv[7:0], 8'hC7);
    host.frame(`OP_WRITE_ENABLE, 1'b1, 0);
    host.frame(`OP_WRITE_SECSTAT, 1'b1, 0);
    chk("frozen", stat, 8'hC7);
    $display("test flags done");
    report_and_stop;
end
endmodule // secure_otp_and_security_status_test
